// *** shared/mcs_regs.svh ***
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
// byte offsets on the register bus
`define MCS_OFF_SETUP 6'h00
`define MCS_OFF_ENABLE 6'h04
`define MCS_OFF_STATUS 6'h08
`define MCS_OFF_CAL 6'h0c
`define MCS_OFF_OC 6'h10
`define MCS_OFF_OP 6'h14
`define MCS_OFF_UV 6'h18
`define MCS_OFF_OV 6'h1c
`define MCS_OFF_RES 6'h20
`define MCS_OFF_END 6'h30
// setup register fields
`define MCS_MODE_LSB 0
`define MCS_SCT_LSB 3
`define MCS_BCT_LSB 6
`define MCS_AVG_LSB 9
// status and enable bits
`define MCS_F_OC 0
`define MCS_F_OP 1
`define MCS_F_OV 2
`define MCS_F_UV 3
`define MCS_F_CML 4
`define MCS_F_OVF 5
`define MCS_F_CNVR 6
// reset values
`define MCS_RST_SETUP 16'h0127
`define MCS_RST_ENABLE 16'h0000
`define MCS_RST_CAL 16'h0000
`define MCS_RST_OC 16'h7ff0
`define MCS_RST_OP 16'hfff0
`define MCS_RST_UV 16'h8000
`define MCS_RST_OV 16'h7ff0
// timing
`define MCS_CLK_MHZ 100
`define MCS_SAMPLE_KHZ 500
`define MCS_WAKE_US 40
`define MCS_WAKE_CYC (`MCS_WAKE_US * `MCS_CLK_MHZ)
`define MCS_CT0_US 140
`define MCS_CT1_US 204
`define MCS_CT2_US 332
`define MCS_CT3_US 588
`define MCS_CT4_US 1100
`define MCS_CT5_US 2116
`define MCS_CT6_US 4156
`define MCS_CT7_US 8244
// averaging counts as powers of two
`define MCS_AVG0_SH 4'd0
`define MCS_AVG1_SH 4'd2
`define MCS_AVG2_SH 4'd4
`define MCS_AVG3_SH 4'd6
`define MCS_AVG4_SH 4'd7
`define MCS_AVG5_SH 4'd8
`define MCS_AVG6_SH 4'd9
`define MCS_AVG7_SH 4'd10
`endif

// *** shared/mcs_pkg.sv ***
// Purpose: types shared by the conversion sequencer
// Assumes: 32-bit avalon data, 16-bit registers
// Notes: state codes are one-hot
package mcs_pkg;
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } mcs_av_req_t;
    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
    } mcs_raw_t;
    typedef enum logic [5:0] {
        st_off = 6'h01,
        st_wake = 6'h02,
        st_shunt = 6'h04,
        st_bus = 6'h08,
        st_post = 6'h10,
        st_idle = 6'h20
    } mcs_state_t;
endpackage : mcs_pkg

// *** logic/mcs_top.sv ***
// Purpose: conversion sequencer, averaging, warnings and alert for a power monitor
// Assumes: converter results stable at conversion end; sample clock is a pin
// Notes: registers on avalon-mm, one word each
// Notes on behaviour
// [RL1] alert pin reports every warning, fault, overflow and ready, several at once
// [RL2] host-set current, power, bus under and over limits raise warnings
// [RL3] bus communication faults are flagged in the status register
// [RL4] ready and overflow flags are readable in the status register
// [RL5] ready rises when a conversion set finishes and a new one may start
// [RL6] host reads enable or status after each alert to find its cause
// [RL7] continuous mode repeats shunt then bus conversions without host action
// [RL8] current follows each shunt conversion and feeds the power result
// [RL9] sums accumulate to the average count, then all four results update
// [RL10] modes convert shunt only, bus only, or both
// [RL11] each triggered-mode setup write runs exactly one set of conversions
// [RL12] host rewrites setup for each further single shot
// [RL13] power-down stops conversions and switches the input front end off
// [RL14] leaving power-down waits a 40 us recovery before converting
// [RL15] registers stay accessible in power-down
// [RL16] power-down holds until an active mode is written
// [RL17] conversion periods span 140 us to 8.244 ms
// [RL18] shunt period, bus period and average count are separate fields
// [RL19] update interval is the sum of periods times the average count
// [RL20] conversion periods are counted in 500 kHz sample clock edges
// [RL21] host picks longest periods and most averages its timing allows
// [RL22] ready is set only after conversions, averaging and products finish
// [RL23] ready clears on non-power-down setup writes and enable register reads
// [RL24] power uses previous current and new bus value, adding no time
// [RL25] register access is fast enough for a 400 kHz serial host
// [RL26] alert drives low while an enabled flag is latched, releases when cleared
// [RL27] overflow flag sets when a computed result leaves 16-bit range
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`include "mcs_regs.svh"
module mcs_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire mcs_pkg::mcs_av_req_t av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // converter
    input wire logic sample_clk_pin,
    input wire mcs_pkg::mcs_raw_t raw,
    output logic frontend_on,
    // open-drain alert pin
    input wire logic alert_i,
    output logic alert_o,
    output logic alert_oe_b
);
    import mcs_pkg::*;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge

    function automatic logic [15:0] cfg_rst(input logic [2:0] i);
        case (i)
            3'h0: cfg_rst = `MCS_RST_SETUP;
            3'h1: cfg_rst = `MCS_RST_ENABLE;
            3'h3: cfg_rst = `MCS_RST_CAL;
            3'h4: cfg_rst = `MCS_RST_OC;
            3'h5: cfg_rst = `MCS_RST_OP;
            3'h6: cfg_rst = `MCS_RST_UV;
            3'h7: cfg_rst = `MCS_RST_OV;
            default: cfg_rst = 16'h0000;
        endcase
    endfunction : cfg_rst

    function automatic logic [12:0] ct_samples(input logic [2:0] s);
        int us;
        case (s)
            3'h0: us = `MCS_CT0_US;
            3'h1: us = `MCS_CT1_US;
            3'h2: us = `MCS_CT2_US;
            3'h3: us = `MCS_CT3_US;
            3'h4: us = `MCS_CT4_US;
            3'h5: us = `MCS_CT5_US;
            3'h6: us = `MCS_CT6_US;
            default: us = `MCS_CT7_US;
        endcase
        ct_samples = 13'(us * `MCS_SAMPLE_KHZ / 1000);
    endfunction : ct_samples

    function automatic logic [3:0] avg_sh(input logic [2:0] s);
        case (s)
            3'h0: avg_sh = `MCS_AVG0_SH;
            3'h1: avg_sh = `MCS_AVG1_SH;
            3'h2: avg_sh = `MCS_AVG2_SH;
            3'h3: avg_sh = `MCS_AVG3_SH;
            3'h4: avg_sh = `MCS_AVG4_SH;
            3'h5: avg_sh = `MCS_AVG5_SH;
            3'h6: avg_sh = `MCS_AVG6_SH;
            default: avg_sh = `MCS_AVG7_SH;
        endcase
    endfunction : avg_sh

    function automatic logic is_pd(input logic [2:0] m);
        is_pd = (m[1:0] == 2'b00);
    endfunction : is_pd

    function automatic mcs_state_t first_st(input logic [2:0] m);
        first_st = m[0] ? st_shunt : st_bus;
    endfunction : first_st

    function automatic logic signed [26:0] acc_add(input logic signed [26:0] a,
                                                   input logic en, input logic [15:0] v);
        acc_add = en ? a + {{11{v[15]}}, v} : a;
    endfunction : acc_add

    function automatic logic [15:0] avg16(input logic signed [26:0] a, input logic [3:0] s);
        logic signed [26:0] t;
        t = a >>> s;
        avg16 = t[15:0];
    endfunction : avg16

    // register bus slave
    logic wait_q;
    logic [31:0] rdata_q;
    logic [15:0] cfg_q [0:7];
    logic [15:0] res_q [0:3];
    logic [6:0] stat_q;
    logic alert_lvl_q;
    wire req = av_req.read | av_req.write;
    wire acc = req & ~wait_q;
    wire acc_wr = acc & av_req.write;
    wire acc_rd = acc & av_req.read;
    wire [5:0] adr = av_req.address;
    wire [2:0] cidx = adr[4:2];
    wire mapped = (adr[1:0] == 2'b00) & (adr < `MCS_OFF_END);
    wire is_res = mapped & (adr >= `MCS_OFF_RES);
    wire is_stat = (adr == `MCS_OFF_STATUS);
    wire wr_cfg = acc_wr & mapped & ~is_res & ~is_stat;
    wire wr_setup = acc_wr & (adr == `MCS_OFF_SETUP);
    wire wr_stat = acc_wr & is_stat;
    wire rd_en = acc_rd & (adr == `MCS_OFF_ENABLE);
    // a write to a result register is refused like an unmapped access
    wire bad = acc & (~mapped | (av_req.write & is_res));
    wire [15:0] cfg_wr = merge(cfg_q[cidx], av_req.writedata[15:0], av_req.byteenable[1:0]);
    wire [15:0] rd_cfg = is_stat ? {8'h00, alert_lvl_q, stat_q} : cfg_q[cidx];
    wire [15:0] rd_res = res_q[adr[3:2]];
    wire [31:0] rd_word = mapped ? {16'h0000, is_res ? rd_res : rd_cfg} : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~(req & wait_q); // [RL25] [RL15]
            if (req & wait_q) begin
                rdata_q <= rd_word;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++) begin
                cfg_q[i] <= cfg_rst(3'(i));
            end
        end else if (wr_cfg) begin
            cfg_q[cidx] <= cfg_wr; // [RL2] [RL18]
        end
    end

    // setup fields
    wire [15:0] setup = cfg_q[0];
    wire [2:0] mode = setup[`MCS_MODE_LSB +: 3]; // [RL10]
    wire [2:0] sct = setup[`MCS_SCT_LSB +: 3]; // [RL18]
    wire [2:0] bct = setup[`MCS_BCT_LSB +: 3];
    wire [2:0] asel = setup[`MCS_AVG_LSB +: 3];
    wire [2:0] nmode = cfg_wr[`MCS_MODE_LSB +: 3];
    wire [15:0] en = cfg_q[1];
    wire [15:0] cal = cfg_q[3];

    // sample clock pin: three stages, edge once the later two agree
    logic [2:0] sclk_q;
    logic sclk_lvl_q;
    logic [2:0] apin_q;
    wire sclk_agree = (sclk_q[1] == sclk_q[2]);
    wire samp_edge = sclk_agree & sclk_q[2] & ~sclk_lvl_q; // [RL20]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 3'h0;
            sclk_lvl_q <= 1'b0;
            apin_q <= 3'h7;
            alert_lvl_q <= 1'b1;
        end else begin
            sclk_q <= {sclk_q[1:0], sample_clk_pin};
            apin_q <= {apin_q[1:0], alert_i};
            if (sclk_agree) begin
                sclk_lvl_q <= sclk_q[2];
            end
            if (apin_q[1] == apin_q[2]) begin
                alert_lvl_q <= apin_q[2];
            end
        end
    end

    // sequencer
    mcs_state_t st_q;
    mcs_state_t st_d;
    logic [12:0] samp_q;
    logic [11:0] wake_q;
    logic [10:0] navg_q;
    wire [12:0] ct_now = ct_samples(st_q == st_shunt ? sct : bct); // [RL17]
    wire conv_end = samp_edge & (samp_q == ct_now - 13'd1);
    wire [3:0] sh = avg_sh(asel);
    wire [10:0] avg_n = 11'd1 << sh;
    wire last = (navg_q == avg_n - 11'd1); // [RL19]
    wire upd = (st_q == st_post) & last;
    wire wake_done = (wake_q == 12'(`MCS_WAKE_CYC - 1));

    always_comb begin
        st_d = st_q;
        if (wr_setup) begin
            if (is_pd(nmode)) begin
                st_d = st_off; // [RL13]
            end else if (st_q == st_off || st_q == st_wake) begin
                st_d = st_wake; // [RL14]
            end else begin
                st_d = first_st(nmode); // [RL11]
            end
        end else begin
            unique case (st_q)
                st_off: st_d = st_off; // [RL16]
                st_wake: if (wake_done) st_d = first_st(mode);
                st_shunt: if (conv_end) st_d = mode[1] ? st_bus : st_post; // [RL7]
                st_bus: if (conv_end) st_d = st_post;
                st_post: st_d = (last & ~mode[2]) ? st_idle : first_st(mode); // [RL7]
                st_idle: st_d = st_idle; // [RL12]
                default: st_d = st_off;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= st_wake;
            samp_q <= 13'h0000;
            wake_q <= 12'h000;
        end else begin
            st_q <= st_d;
            samp_q <= (st_d != st_q || wr_setup) ? 13'h0000 : samp_q + 13'(samp_edge);
            wake_q <= (st_q != st_wake) ? 12'h000 : wake_q + 12'(!wake_done); // [RL14]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            navg_q <= 11'h000;
        end else if (wr_setup || upd) begin
            navg_q <= 11'h000; // [RL9]
        end else if (st_q == st_post) begin
            navg_q <= navg_q + 11'd1;
        end
    end

    // arithmetic; a skipped input reuses its last value
    logic [15:0] last_sh_q;
    logic [15:0] last_bus_q;
    logic [15:0] last_cur_q;
    logic signed [26:0] acc_q [0:3];
    wire sh_take = (st_q == st_shunt) & conv_end;
    wire bus_take = (st_q == st_bus) & conv_end;
    wire add_sh = sh_take | ((st_q == st_post) & ~mode[0]);
    wire add_bus = bus_take | ((st_q == st_post) & ~mode[1]);
    wire [15:0] sh_val = sh_take ? raw.shunt : last_sh_q;
    wire [15:0] bus_val = bus_take ? raw.bus : last_bus_q;
    wire signed [32:0] cur_full = $signed(sh_val) * $signed({1'b0, cal}); // [RL8]
    wire [15:0] cur_val = cur_full[26:11];
    // power takes the current held from the shunt step, so it costs no time
    wire signed [31:0] pw_full = $signed(last_cur_q) * $signed(bus_val); // [RL24]
    wire [15:0] pw_val = pw_full[27:12];
    wire cur_ovf = add_sh & (cur_full[32:27] != {6{cur_full[26]}}); // [RL27]
    wire pw_ovf = add_bus & (pw_full[31:28] != {4{pw_full[27]}});
    wire signed [26:0] sh_acc_d = acc_add(acc_q[0], add_sh, sh_val);
    wire signed [26:0] bus_acc_d = acc_add(acc_q[1], add_bus, bus_val);
    wire signed [26:0] cur_acc_d = acc_add(acc_q[2], add_sh, cur_val);
    wire signed [26:0] pw_acc_d = acc_add(acc_q[3], add_bus, pw_val);
    wire [15:0] sh_avg = avg16(sh_acc_d, sh);
    wire [15:0] bus_avg = avg16(bus_acc_d, sh);
    wire [15:0] cur_avg = avg16(cur_acc_d, sh);
    wire [15:0] pw_avg = avg16(pw_acc_d, sh);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_sh_q <= 16'h0000;
            last_bus_q <= 16'h0000;
            last_cur_q <= 16'h0000;
        end else begin
            if (add_sh) begin
                last_sh_q <= sh_val;
                last_cur_q <= cur_val; // [RL8]
            end
            if (add_bus) begin
                last_bus_q <= bus_val;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= 27'sh0;
                res_q[i] <= 16'h0000;
            end
        end else if (wr_setup || upd) begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= 27'sh0;
            end
            if (upd) begin
                res_q[0] <= sh_avg; // [RL9]
                res_q[1] <= bus_avg;
                res_q[2] <= cur_avg;
                res_q[3] <= pw_avg;
            end
        end else begin
            acc_q[0] <= sh_acc_d;
            acc_q[1] <= bus_acc_d;
            acc_q[2] <= cur_acc_d;
            acc_q[3] <= pw_acc_d;
        end
    end

    // warnings use the upper 12 bits only
    wire oc_hit = $signed(cur_avg[15:4]) > $signed(cfg_q[4][15:4]); // [RL2]
    wire op_hit = pw_avg[15:4] > cfg_q[5][15:4];
    wire uv_hit = $signed(bus_avg[15:4]) < $signed(cfg_q[6][15:4]);
    wire ov_hit = $signed(bus_avg[15:4]) > $signed(cfg_q[7][15:4]);

    // status flags: hardware set wins over any clear in the same cycle
    logic [6:0] set_v;
    logic [6:0] clr_v;
    always_comb begin
        set_v = 7'h00;
        set_v[`MCS_F_OC] = upd & oc_hit;
        set_v[`MCS_F_OP] = upd & op_hit;
        set_v[`MCS_F_OV] = upd & ov_hit;
        set_v[`MCS_F_UV] = upd & uv_hit;
        set_v[`MCS_F_CML] = bad; // [RL3]
        set_v[`MCS_F_OVF] = cur_ovf | pw_ovf; // [RL27]
        set_v[`MCS_F_CNVR] = upd; // [RL5] [RL22]
        clr_v = 7'h00;
        if (wr_stat && av_req.byteenable[0]) begin
            clr_v[5:0] = av_req.writedata[5:0];
        end
        clr_v[`MCS_F_CNVR] = (wr_setup & ~is_pd(nmode)) | rd_en; // [RL23]
    end

    logic alert_oe_b_q;
    logic frontend_q;
    wire alert_any = |(stat_q & en[6:0]);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= 7'h00;
            alert_oe_b_q <= 1'b1;
            frontend_q <= 1'b1;
        end else begin
            stat_q <= (stat_q & ~clr_v) | set_v; // [RL4]
            alert_oe_b_q <= ~alert_any; // [RL1] [RL26]
            frontend_q <= (st_d != st_off); // [RL13]
        end
    end

    assign av_readdata = rdata_q;
    assign av_waitrequest = wait_q;
    assign alert_o = 1'b0;
    assign alert_oe_b = alert_oe_b_q;
    assign frontend_on = frontend_q;

    // checks
    property p_cnvr_after_update;
        @(posedge clk) disable iff (!rst_b)
        $rose(stat_q[`MCS_F_CNVR]) |-> $past(st_q) == st_post;
    endproperty
    a_cnvr_after_update: assert property (p_cnvr_after_update) // [RL22]
        else $error("ready rose outside an update");
    property p_cnvr_clear_setup;
        @(posedge clk) disable iff (!rst_b)
        wr_setup && !is_pd(nmode) && !upd |=> !stat_q[`MCS_F_CNVR];
    endproperty
    a_cnvr_clear_setup: assert property (p_cnvr_clear_setup) // [RL23]
        else $error("ready not cleared by setup write");
    property p_cnvr_clear_read;
        @(posedge clk) disable iff (!rst_b)
        rd_en && !upd |=> !stat_q[`MCS_F_CNVR];
    endproperty
    a_cnvr_clear_read: assert property (p_cnvr_clear_read) // [RL23]
        else $error("ready not cleared by enable read");
    property p_alert_follows;
        @(posedge clk) disable iff (!rst_b)
        alert_any |=> !alert_oe_b ##1 (alert_oe_b == !$past(alert_any));
    endproperty
    a_alert_follows: assert property (p_alert_follows) // [RL26]
        else $error("alert pin does not follow latched flags");
    property p_pd_write;
        @(posedge clk) disable iff (!rst_b)
        wr_setup && is_pd(nmode) |=> st_q == st_off ##1 !frontend_on;
    endproperty
    a_pd_write: assert property (p_pd_write) // [RL13]
        else $error("power-down write ignored");
    property p_wake_length;
        @(posedge clk) disable iff (!rst_b)
        st_q == st_wake && st_d != st_wake && !wr_setup |-> wake_done;
    endproperty
    a_wake_length: assert property (p_wake_length) // [RL14]
        else $error("recovery cut short");
    property p_bus_answer;
        @(posedge clk) disable iff (!rst_b)
        req && wait_q |=> !av_waitrequest ##1 av_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) // [RL25]
        else $error("waitrequest did not pulse low");
    property p_one_shot;
        @(posedge clk) disable iff (!rst_b)
        st_q == st_idle && !wr_setup |=> st_q == st_idle;
    endproperty
    a_one_shot: assert property (p_one_shot) // [RL11]
        else $error("idle left without setup write");
    property p_conv_length;
        @(posedge clk) disable iff (!rst_b)
        st_q == st_shunt && st_d != st_shunt && !wr_setup |-> samp_q == ct_now - 13'd1;
    endproperty
    a_conv_length: assert property (p_conv_length) // [RL17]
        else $error("shunt conversion wrong length");
    property p_cml_flag;
        @(posedge clk) disable iff (!rst_b)
        bad |=> stat_q[`MCS_F_CML];
    endproperty
    a_cml_flag: assert property (p_cml_flag) // [RL3]
        else $error("bad access not flagged");
    property p_ovf_flag;
        @(posedge clk) disable iff (!rst_b)
        cur_ovf || pw_ovf |=> stat_q[`MCS_F_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) // [RL27]
        else $error("overflow not flagged");
    property p_continuous;
        @(posedge clk) disable iff (!rst_b)
        upd && mode[2] && !wr_setup |=> st_q == $past(first_st(mode));
    endproperty
    a_continuous: assert property (p_continuous) // [RL7]
        else $error("continuous mode stopped");
    c_update: cover property (@(posedge clk) disable iff (!rst_b) upd);
    c_idle: cover property (@(posedge clk) disable iff (!rst_b) st_q == st_idle);
    c_alert: cover property (@(posedge clk) disable iff (!rst_b) $fell(alert_oe_b));
    c_wake: cover property (@(posedge clk) disable iff (!rst_b) st_q == st_wake && wake_done);
endmodule : mcs_top

// *** dv/mcs_adc_model.sv ***
// Purpose: converter side: free sample clock and fixed results
// Assumes: results change only on sample edges, far from conversion end
// Notes: front end off gives a toggling pattern, every other sample equal to the powered value
module mcs_adc_model (
    // control
    input wire logic frontend_on,
    // converter
    output logic sample_clk_pin,
    output mcs_pkg::mcs_raw_t raw
);
    timeunit 1ns;
    timeprecision 1ps;
    import mcs_pkg::*;
    logic flip_q = 1'b0;
    initial begin
        sample_clk_pin = 1'b0;
        forever #40 sample_clk_pin = ~sample_clk_pin;
    end
    // unpowered inputs carry no usable value: a pattern that flips every sample
    always @(posedge sample_clk_pin) flip_q <= ~flip_q;
    assign raw = frontend_on ? 32'h0123_0456 : ({32{flip_q}} ^ 32'hfedc_fba9);
endmodule : mcs_adc_model

// *** dv/testbench.sv ***
// Purpose: self-checking bench for the conversion sequencer
// Assumes: one bus request at a time, cal 0x0800 gives current = shunt
// Notes: ready is polled through status, no fixed waits except four clocks for the alert pin level
`include "mcs_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mcs_pkg::*;
    logic clk, rst_b, av_waitrequest, sample_clk_pin, frontend_on;
    logic alert_o, alert_oe_b, alert_w;
    logic [31:0] av_readdata, q;
    mcs_av_req_t av_req;
    mcs_raw_t raw;
    int fail_count, comparisons, cyc, t0;
    // pull-up on the shared alert line
    assign alert_w = alert_oe_b ? 1'b1 : alert_o;
    mcs_top DUT (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .sample_clk_pin(sample_clk_pin), .raw(raw),
        .frontend_on(frontend_on), .alert_i(alert_w), .alert_o(alert_o),
        .alert_oe_b(alert_oe_b));
    mcs_adc_model adc (.frontend_on(frontend_on), .sample_clk_pin(sample_clk_pin),
        .raw(raw));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task summarize;
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // extra edge after release keeps two requests out of one time step
    task bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        av_req <= '{read: !w, write: w, address: a, byteenable: 4'h3,
            writedata: {16'h0000, d}};
        @(posedge clk);
        while (av_waitrequest !== 1'b0) @(posedge clk);
        q = av_readdata;
        av_req <= '0;
        @(posedge clk);
    endtask : bus
    task wait_rdy;
        for (int i = 0; i < 3000; i++) begin
            bus(1'b0, `MCS_OFF_STATUS, 16'h0000);
            if (q[6] === 1'b1) break;
        end
        chk(q[6], 1'b1);
    endtask : wait_rdy
    task t_reset;
        bus(1'b0, `MCS_OFF_SETUP, 16'h0000);
        chk(q, 32'h00000127);
        bus(1'b0, `MCS_OFF_OC, 16'h0000);
        chk(q, 32'h00007ff0);
        bus(1'b0, `MCS_OFF_UV, 16'h0000);
        chk(q, 32'h00008000);
    endtask : t_reset
    task t_fault;
        bus(1'b0, `MCS_OFF_END, 16'h0000);
        chk(q, 32'h00000000);
        bus(1'b1, `MCS_OFF_RES, 16'hbeef);
        bus(1'b0, `MCS_OFF_RES, 16'h0000);
        chk(q === 32'h0000beef, 1'b0);
        bus(1'b0, `MCS_OFF_STATUS, 16'h0000);
        chk(q[4], 1'b1);
        bus(1'b1, `MCS_OFF_STATUS, 16'h0010);
        bus(1'b0, `MCS_OFF_STATUS, 16'h0000);
        chk(q[4], 1'b0);
    endtask : t_fault
    // single shot, both inputs, shortest periods, no averaging
    task t_trig;
        bus(1'b1, `MCS_OFF_CAL, 16'h0800);
        bus(1'b1, `MCS_OFF_ENABLE, 16'h0040);
        bus(1'b1, `MCS_OFF_SETUP, 16'h0003);
        wait_rdy();
        // the pin level reaches status through four flops, so look again later
        repeat (4) @(posedge clk);
        bus(1'b0, `MCS_OFF_STATUS, 16'h0000);
        chk(q[7], 1'b0);
        chk(alert_oe_b, 1'b0);
        chk(alert_w, 1'b0);
        bus(1'b0, `MCS_OFF_RES, 16'h0000);
        chk(q, 32'h00000123);
        bus(1'b0, `MCS_OFF_RES + 6'h04, 16'h0000);
        chk(q, 32'h00000456);
        bus(1'b0, `MCS_OFF_RES + 6'h08, 16'h0000);
        chk(q, 32'h00000123);
        bus(1'b0, `MCS_OFF_RES + 6'h0c, 16'h0000);
        chk(q, 32'h0000004e);
        bus(1'b0, `MCS_OFF_ENABLE, 16'h0000);
        bus(1'b0, `MCS_OFF_STATUS, 16'h0000);
        chk(q[6], 1'b0);
        chk(alert_oe_b, 1'b1);
        // a further shot needs a further setup write, same mode
        bus(1'b1, `MCS_OFF_SETUP, 16'h0003);
        wait_rdy();
        bus(1'b0, `MCS_OFF_RES + 6'h04, 16'h0000);
        chk(q, 32'h00000456);
    endtask : t_trig
    task t_cont;
        bus(1'b1, `MCS_OFF_OV, 16'h0400);
        bus(1'b1, `MCS_OFF_SETUP, 16'h0007);
        wait_rdy();
        bus(1'b0, `MCS_OFF_ENABLE, 16'h0000);
        wait_rdy();
        chk(q[2], 1'b1);
    endtask : t_cont
    task t_pd;
        // longest periods and most averages, as a careful host would choose
        bus(1'b1, `MCS_OFF_SETUP, 16'h0fff);
        bus(1'b0, `MCS_OFF_SETUP, 16'h0000);
        chk(q, 32'h00000fff);
        bus(1'b1, `MCS_OFF_SETUP, 16'h0000);
        bus(1'b1, `MCS_OFF_OC, 16'h1230);
        bus(1'b0, `MCS_OFF_OC, 16'h0000);
        chk(q, 32'h00001230);
        bus(1'b0, `MCS_OFF_SETUP, 16'h0000);
        chk(q, 32'h00000000);
        chk(frontend_on, 1'b0);
        t0 = cyc;
        bus(1'b1, `MCS_OFF_SETUP, 16'h0003);
        chk(frontend_on, 1'b1);
        wait_rdy();
        chk((cyc - t0) >= `MCS_WAKE_CYC, 1'b1);
    endtask : t_pd
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
    initial begin
        rst_b = 1'b0;
        av_req = '0;
        cyc = 0;
        fail_count = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fault();
        t_trig();
        t_cont();
        t_pd();
        summarize();
    end
endmodule : testbench
